// ### hdl/timer8_single_compare.sv
// Purpose: 8-bit timer/counter with one compare channel behind a classic Wishbone slave.
// Assumes: One clock, synchronous active-high reset, external count pin synchronous to clk_i.
// Notes: Interrupt requests are levels; the acknowledge inputs clear the flags.
// Function
// - Counter and compare registers are eight bits, readable and writable.
// - Tick comes from prescaler or the external pin with chosen edge.
// - Clock select zero gives no tick, counter stops.
// - Bottom indication asserts when counter is zero.
// - Maximum is 0xff, max indication asserts there.
// - Top is 0xff or the compare value, per mode.
// - Each tick clears, increments or decrements the counter by mode.
// - CPU may access counter anytime; its write beats clear or count.
// - Mode field picks sequence; overflow flag set at mode point.
// - Counter equal compare sets match flag at next tick.
// - Compare request is flag and enable and global interrupt flag.
// - Match flag clears on interrupt execution or written one.
// - Compare value double buffered in PWM modes only.
// - Buffered value moves to active register only at top or bottom.
// - CPU compare accesses go to buffer when buffered, else active.
// - Force strobe in non-PWM modes updates output only, no flag.
// - Counter write blocks compare match in next tick, even stopped.
// - Output state is kept across waveform mode changes.
// - Output mode bits are unbuffered and act immediately.
// - Mode zero counts up, wraps, overflow with becoming zero.
// - Mode two clears counter on match; compare is top.
// - Mode three counts bottom to max single slope, overflow at max.
// - Output mode zero takes no action on match.
//
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
module timer8_single_compare
  import timer8_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic external_count_pin_i,
  input wire logic global_irq_enable_i,
  input wire logic compare_irq_taken_i,
  input wire logic overflow_irq_taken_i,
  output logic compare_irq_o,
  output logic overflow_irq_o,
  output logic compare_output_o,
  output logic bottom_o,
  output logic max_o
);

  typedef struct packed {
    logic [31:0] dat;
    logic ack;
    logic [2:0] clock_source_select;
    logic [1:0] waveform_mode_select;
    logic [1:0] compare_output_mode;
    logic [7:0] timer_count_value;
    logic [7:0] compare_value_reg;
    logic [7:0] compare_buffer;
    logic overflow_flag;
    logic compare_match_flag;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic compare_output;
    logic count_down;
    logic block_match;
    logic [PRESCALE_W-1:0] prescale;
    logic pin_last;
    logic cmp_irq;
    logic ovf_irq;
    logic bottom;
    logic max;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic access;
  logic wr;
  logic tick;
  logic pwm_mode;
  logic match_now;
  logic [7:0] top_val;
  logic buffer_load;

  // Prescaler taps: a divide by two to the n tick fires when the low n bits of the free-running count are all ones.
  // Sharing one counter keeps all rates in step, at the cost of a first tick that may come early after a switch.
  localparam int DIV8_W = 3;
  localparam int DIV64_W = 6;
  localparam int DIV256_W = 8;

  // Bus strobe: one access per cycle with no ack pending, so ack lasts one cycle.
  assign access = wb_cyc_i && wb_stb_i && !st_reg.ack;
  assign wr = access && wb_we_i && wb_sel_i[0];

  assign pwm_mode = (st_reg.waveform_mode_select == WGM_PHASE) || (st_reg.waveform_mode_select == WGM_FAST);

  assign top_val = (st_reg.waveform_mode_select == WGM_CTC) ? st_reg.compare_value_reg : MAX_VAL;

  assign match_now = (st_reg.timer_count_value == st_reg.compare_value_reg);

  assign buffer_load = tick && pwm_mode && st_reg.timer_count_value == MAX_VAL &&
                       (st_reg.waveform_mode_select == WGM_FAST || !st_reg.count_down);

  always_comb begin
    case (st_reg.clock_source_select)
      CS_STOP: tick = 1'b0;
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = &st_reg.prescale[DIV8_W-1:0];
      CS_DIV64: tick = &st_reg.prescale[DIV64_W-1:0];
      CS_DIV256: tick = &st_reg.prescale[DIV256_W-1:0];
      CS_DIV1024: tick = &st_reg.prescale;
      CS_EXT_FALL: tick = st_reg.pin_last && !external_count_pin_i;
      default: tick = !st_reg.pin_last && external_count_pin_i;
    endcase
  end

  // Main next-state logic; the counter and compare paths share one pass so priorities stay visible.
  always_comb begin
    st_next = st_reg;
    st_next.ack = access;
    st_next.pin_last = external_count_pin_i;
    st_next.prescale = st_reg.prescale + {{(PRESCALE_W-1){1'b0}}, 1'b1};
    st_next.dat = 32'h0000_0000;
    // Reads return low byte, upper bits zero; unmapped reads zero.
    // Eight-bit register reads
    if (access && !wb_we_i) begin
      case (wb_adr_i)
        ADDR_CONTROL: st_next.dat[7:0] = {1'b0, st_reg.compare_output_mode, st_reg.waveform_mode_select,
                                          st_reg.clock_source_select};
        ADDR_COUNT: st_next.dat[7:0] = st_reg.timer_count_value;
        ADDR_COMPARE: st_next.dat[7:0] = pwm_mode ? st_reg.compare_buffer : st_reg.compare_value_reg;
        ADDR_MASK: st_next.dat[7:0] = {6'h00, st_reg.compare_irq_enable, st_reg.overflow_irq_enable};
        ADDR_FLAG: st_next.dat[7:0] = {6'h00, st_reg.compare_match_flag, st_reg.overflow_flag};
        ADDR_BUFFER: st_next.dat[7:0] = st_reg.compare_value_reg;
        default: st_next.dat = 32'h0000_0000;
      endcase
    end
    // Clear-on-one happens first, so a hardware set later in this pass wins.
    // Flag clear paths
    if (compare_irq_taken_i) st_next.compare_match_flag = 1'b0;
    if (overflow_irq_taken_i) st_next.overflow_flag = 1'b0;
    if (wr && wb_adr_i == ADDR_FLAG) begin
      if (wb_dat_i[OCF_BIT]) st_next.compare_match_flag = 1'b0;
      if (wb_dat_i[OVF_BIT]) st_next.overflow_flag = 1'b0;
    end
    // A tick consumes the block left by an earlier counter write.
    if (tick) begin
      st_next.block_match = 1'b0;
    end
    // The comparator result is taken at the tick that ends the cycle in which counter and compare agree,
    // so the flag lands one tick after the match; a write-armed block swallows exactly that one tick.
    // Match flagged next tick
    if (tick && match_now && !st_reg.block_match) begin
      st_next.compare_match_flag = 1'b1;
      case (st_reg.compare_output_mode)
        COM_TOGGLE: st_next.compare_output = pwm_mode ? st_reg.compare_output : !st_reg.compare_output;
        COM_CLEAR: st_next.compare_output = st_reg.count_down ? 1'b1 : 1'b0;
        COM_SET: st_next.compare_output = st_reg.count_down ? 1'b0 : 1'b1;
        default: st_next.compare_output = st_reg.compare_output;
      endcase
    end
    if (tick) begin
      case (st_reg.waveform_mode_select)
        WGM_CTC: begin
          if (st_reg.timer_count_value == top_val) st_next.timer_count_value = BOTTOM_VAL;
          else st_next.timer_count_value = st_reg.timer_count_value + ONE_VAL;
          if (st_reg.timer_count_value == MAX_VAL) st_next.overflow_flag = 1'b1;
        end
        WGM_PHASE: begin
          if (!st_reg.count_down && st_reg.timer_count_value == MAX_VAL) begin
            st_next.count_down = 1'b1;
            st_next.timer_count_value = st_reg.timer_count_value - ONE_VAL;
          end else if (st_reg.count_down && st_reg.timer_count_value == BOTTOM_VAL) begin
            st_next.count_down = 1'b0;
            st_next.overflow_flag = 1'b1;
            st_next.timer_count_value = ONE_VAL;
          end else if (st_reg.count_down) begin
            st_next.timer_count_value = st_reg.timer_count_value - ONE_VAL;
          end else begin
            st_next.timer_count_value = st_reg.timer_count_value + ONE_VAL;
          end
        end
        default: begin
          st_next.count_down = 1'b0;
          st_next.timer_count_value = st_reg.timer_count_value + ONE_VAL;
          if (st_reg.timer_count_value == MAX_VAL) st_next.overflow_flag = 1'b1;
        end
      endcase
      if (buffer_load) st_next.compare_value_reg = st_reg.compare_buffer;
      // Fast PWM output returns at bottom, opposite to the match action.
      if (st_reg.waveform_mode_select == WGM_FAST && st_reg.timer_count_value == MAX_VAL) begin
        if (st_reg.compare_output_mode == COM_CLEAR) st_next.compare_output = 1'b1;
        if (st_reg.compare_output_mode == COM_SET) st_next.compare_output = 1'b0;
      end
    end
    // Register writes come last so the CPU overrides counting.
    if (wr) begin
      case (wb_adr_i)
        ADDR_CONTROL: begin
          st_next.clock_source_select = wb_dat_i[CS_LSB +: 3];
          st_next.waveform_mode_select = wb_dat_i[WGM_LSB +: 2];
          st_next.compare_output_mode = wb_dat_i[COM_LSB +: 2];
          if (wb_dat_i[FOC_BIT] && !(wb_dat_i[WGM_LSB] ^ 1'b0)) begin
            case (wb_dat_i[COM_LSB +: 2])
              COM_TOGGLE: st_next.compare_output = !st_reg.compare_output;
              COM_CLEAR: st_next.compare_output = 1'b0;
              COM_SET: st_next.compare_output = 1'b1;
              default: st_next.compare_output = st_reg.compare_output;
            endcase
          end
        end
        ADDR_COUNT: begin
          st_next.timer_count_value = wb_dat_i[7:0];
          st_next.block_match = 1'b1;
        end
        ADDR_COMPARE: begin
          if (pwm_mode) st_next.compare_buffer = wb_dat_i[7:0];
          else begin
            st_next.compare_value_reg = wb_dat_i[7:0];
            st_next.compare_buffer = wb_dat_i[7:0];
          end
        end
        ADDR_MASK: begin
          st_next.compare_irq_enable = wb_dat_i[OCIE_BIT];
          st_next.overflow_irq_enable = wb_dat_i[TOIE_BIT];
        end
        default: st_next.compare_buffer = st_next.compare_buffer;
      endcase
    end
    st_next.cmp_irq = st_next.compare_match_flag && st_next.compare_irq_enable && global_irq_enable_i;
    st_next.ovf_irq = st_next.overflow_flag && st_next.overflow_irq_enable && global_irq_enable_i;
    st_next.bottom = (st_next.timer_count_value == BOTTOM_VAL);
    st_next.max = (st_next.timer_count_value == MAX_VAL);
  end

  // State register; reset brings everything to zero, bottom asserted since the count is zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.bottom <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_o = st_reg.dat;
  assign wb_ack_o = st_reg.ack;
  assign compare_irq_o = st_reg.cmp_irq;
  assign overflow_irq_o = st_reg.ovf_irq;
  assign compare_output_o = st_reg.compare_output;
  assign bottom_o = st_reg.bottom;
  assign max_o = st_reg.max;

  // Checks.
  sequence count_write_s;
    wr && wb_adr_i == ADDR_COUNT;
  endsequence

  // A match that counts: a tick while counter and compare agree, with no write block armed.
  sequence match_tick_s;
    tick && match_now && !st_reg.block_match;
  endsequence

  write_blocks_a: assert property (@(posedge clk_i) disable iff (rst_i)
    count_write_s |=> st_reg.block_match) else $error("Counter write did not arm the block.");
  stopped_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.clock_source_select == CS_STOP && !wr) |=> $stable(st_reg.timer_count_value))
    else $error("Counter moved while stopped.");
  write_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    count_write_s |=> st_reg.timer_count_value == $past(wb_dat_i[7:0])) else $error("Counter write lost.");
  bottom_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bottom_o == (st_reg.timer_count_value == BOTTOM_VAL)) else $error("Bottom indication wrong.");
  max_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    max_o == (st_reg.timer_count_value == MAX_VAL)) else $error("Max indication wrong.");
  normal_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && st_reg.waveform_mode_select == WGM_NORMAL && st_reg.timer_count_value == MAX_VAL && !wr)
    |=> st_reg.overflow_flag && st_reg.timer_count_value == BOTTOM_VAL) else $error("Normal wrap wrong.");
  ctc_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && st_reg.waveform_mode_select == WGM_CTC && match_now && !wr)
    |=> st_reg.timer_count_value == BOTTOM_VAL) else $error("CTC did not clear.");
  match_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
    match_tick_s |=> st_reg.compare_match_flag) else $error("Match flag not set.");
  buffer_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == ADDR_COMPARE && pwm_mode) |=> st_reg.compare_buffer == $past(wb_dat_i[7:0]) &&
    st_reg.compare_value_reg == ($past(buffer_load) ? $past(st_reg.compare_buffer) : $past(st_reg.compare_value_reg)))
    else $error("Buffered write hit active register.");
  irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    compare_irq_o |-> $past(global_irq_enable_i) && st_reg.compare_match_flag && st_reg.compare_irq_enable)
    else $error("Compare request without cause.");
  ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("Ack held two cycles.");

  // Mode sequences, buffering, output actions, flag clearing, overflow gating and edge counting.
  force_output_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == ADDR_CONTROL && wb_dat_i[FOC_BIT] && !wb_dat_i[WGM_LSB] && wb_dat_i[COM_LSB +: 2] == COM_SET)
    |=> compare_output_o) else $error("Forced set did not reach output.");
  flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == ADDR_FLAG && wb_dat_i[OCF_BIT] && !(tick && match_now && !st_reg.block_match))
    |=> !st_reg.compare_match_flag) else $error("Written one did not clear match flag.");
  buffer_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && st_reg.waveform_mode_select == WGM_FAST && st_reg.timer_count_value == MAX_VAL)
    |=> st_reg.compare_value_reg == $past(st_reg.compare_buffer)) else $error("Buffer not loaded at top.");
  phase_turn_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && st_reg.waveform_mode_select == WGM_PHASE && st_reg.count_down && st_reg.timer_count_value == BOTTOM_VAL && !wr)
    |=> st_reg.overflow_flag && !st_reg.count_down && st_reg.timer_count_value == ONE_VAL) else $error("Bottom turn wrong.");
  fast_ovf_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick && st_reg.waveform_mode_select == WGM_FAST && st_reg.timer_count_value == MAX_VAL && !wr)
    |=> st_reg.overflow_flag && st_reg.timer_count_value == BOTTOM_VAL) else $error("Single slope wrap wrong.");
  direct_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == ADDR_COMPARE && !pwm_mode) |=> st_reg.compare_value_reg == $past(wb_dat_i[7:0]))
    else $error("Unbuffered write missed active register.");
  no_action_a: assert property (@(posedge clk_i) disable iff (rst_i)
    match_tick_s ##0 (st_reg.compare_output_mode == COM_NONE && !wr) |=> $stable(compare_output_o))
    else $error("Output moved with no action mode.");
  mode_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == ADDR_CONTROL && !wb_dat_i[FOC_BIT] && !tick) |=> $stable(compare_output_o))
    else $error("Output changed on control write.");
  ovf_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    overflow_irq_o |-> $past(global_irq_enable_i) && st_reg.overflow_flag && st_reg.overflow_irq_enable)
    else $error("Overflow request without cause.");
  ext_fall_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg.clock_source_select == CS_EXT_FALL && st_reg.pin_last && !external_count_pin_i &&
     st_reg.waveform_mode_select == WGM_NORMAL && !wr)
    |=> st_reg.timer_count_value == $past(st_reg.timer_count_value) + ONE_VAL) else $error("Falling edge not counted.");

endmodule : timer8_single_compare

// ### hdl/timer8_pkg.sv
// Purpose: Shared constants for the 8-bit single compare timer.
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses.
// Notes: Register map and field positions live here only.
package timer8_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h04;
  localparam logic [7:0] ADDR_COMPARE = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  localparam logic [7:0] ADDR_FLAG = 8'h10;
  localparam logic [7:0] ADDR_BUFFER = 8'h14;
  // Control register fields.
  localparam int CS_LSB = 0;
  localparam int WGM_LSB = 3;
  localparam int COM_LSB = 5;
  localparam int FOC_BIT = 7;
  // Flag and mask fields.
  localparam int OVF_BIT = 0;
  localparam int OCF_BIT = 1;
  localparam int OCIE_BIT = 1;
  localparam int TOIE_BIT = 0;
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  localparam logic [7:0] MAX_VAL = 8'hff;
  localparam logic [7:0] ONE_VAL = 8'h01;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [1:0] WGM_NORMAL = 2'h0;
  localparam logic [1:0] WGM_PHASE = 2'h1;
  localparam logic [1:0] WGM_CTC = 2'h2;
  localparam logic [1:0] WGM_FAST = 2'h3;
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  localparam int PRESCALE_W = 10;
endpackage : timer8_pkg

// ### tb/cpu_irq_model.sv
// Purpose: CPU side model that executes timer interrupts.
// Assumes: Requests arrive as levels already gated by the global flag.
// Notes: Takes a request one cycle after it shows, like a vector fetch.
`timescale 1ns/10ps
module cpu_irq_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic gie_i,
  input wire logic compare_irq_i,
  input wire logic overflow_irq_i,
  output logic global_irq_enable_o,
  output logic compare_taken_o,
  output logic overflow_taken_o
);
  // The status register global flag passes straight through.
  assign global_irq_enable_o = gie_i;
  // Execution clears flag.
  // One-cycle pulses; the gap lets the request drop before a second take.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_taken_o <= 1'b0;
      overflow_taken_o <= 1'b0;
    end else begin
      compare_taken_o <= compare_irq_i && !compare_taken_o;
      overflow_taken_o <= overflow_irq_i && !overflow_taken_o;
    end
  end
endmodule : cpu_irq_model

// ### tb/testbench.sv
// Purpose: Self-checking bench for the 8-bit single compare timer.
// Assumes: Slave acks every access; reads are judged by a monitor queue.
// Notes: Timer is stopped before any exact counter read, to avoid races.
`timescale 1ns/10ps
module testbench;
  import timer8_pkg::*;
  typedef struct {logic [31:0] exp; logic [31:0] mask;} note_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, ext_pin = 1'b1, gie = 1'b0, gie_w, cmp_taken, ovf_taken;
  logic compare_irq_o, overflow_irq_o, compare_output_o, bottom_o, max_o;
  note_t notes[$];
  note_t cur;
  int n_fail = 0;
  int compares = 0;
  logic [1:0] ovf_modes [3] = '{WGM_NORMAL, WGM_PHASE, WGM_FAST};
  logic [1:0] force_com [4] = '{COM_SET, COM_NONE, COM_CLEAR, COM_TOGGLE};
  logic force_out [4] = '{1'b1, 1'b1, 1'b0, 1'b1};

  always #2 clk_i = ~clk_i;

  timer8_single_compare dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .external_count_pin_i(ext_pin), .global_irq_enable_i(gie_w),
    .compare_irq_taken_i(cmp_taken), .overflow_irq_taken_i(ovf_taken), .compare_irq_o(compare_irq_o),
    .overflow_irq_o(overflow_irq_o), .compare_output_o(compare_output_o), .bottom_o(bottom_o), .max_o(max_o));
  cpu_irq_model cpu (.clk_i(clk_i), .rst_i(rst_i), .gie_i(gie), .compare_irq_i(compare_irq_o),
    .overflow_irq_i(overflow_irq_o), .global_irq_enable_o(gie_w), .compare_taken_o(cmp_taken),
    .overflow_taken_o(ovf_taken));

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic check_bit(input string what, input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic ticks(input int n);
    repeat (n) @(posedge clk_i);
  endtask : ticks

  // One classic cycle; request held until ack is sampled, then released.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d, input logic [3:0] sel);
    int i;
    i = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= sel;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    if (wb_ack_o !== 1'b1) begin
      n_fail++;
      $display("[FAIL] wb_ack_o expected 1 seen %b", wb_ack_o);
      complete_run();
    end else begin
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
    end
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    wb(1'b1, adr, d, 4'h1);
  endtask : wr

  task automatic rd(input logic [7:0] adr, input logic [7:0] exp, input logic [7:0] mask = 8'hff);
    notes.push_back('{{24'h0, exp}, {24'hffffff, mask}});
    wb(1'b0, adr, 8'h00, 4'hf);
  endtask : rd

  // Read data is judged at the ack edge against the oldest note.
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && notes.size() > 0) begin
      cur = notes.pop_front();
      compares++;
      if ((wb_dat_o & cur.mask) !== cur.exp) begin
        n_fail++;
        $display("[FAIL] wb_dat_o expected %h seen %h", cur.exp, wb_dat_o & cur.mask);
      end
    end
  end

  initial begin
    int k;
    int n_edges;
    logic [7:0] r;
    void'($urandom(32'h670f7f94));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADDR_CONTROL, 8'h00); // Control resets stopped.
    rd(ADDR_COUNT, 8'h00); // Counter resets clear.
    rd(ADDR_FLAG, 8'h00); // Flags reset clear.
    check_bit("bottom_o", bottom_o, 1'b1); // Zero count shows bottom.
    // Force initialises output
    // Force strobe in normal mode walks the output through every mode.
    for (k = 0; k < 4; k++) begin
      wr(ADDR_CONTROL, {1'b1, force_com[k], WGM_NORMAL, CS_STOP});
      ticks(2);
      check_bit("compare_output_o", compare_output_o, force_out[k]); // Forced action.
    end
    rd(ADDR_FLAG, 8'h00); // No flag from force.
    wr(ADDR_CONTROL, {1'b0, COM_NONE, WGM_FAST, CS_STOP});
    ticks(2);
    check_bit("compare_output_o", compare_output_o, 1'b1); // Kept across mode change.
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT, 8'hff);
    ticks(2);
    check_bit("max_o", max_o, 1'b1); // Max shows at 0xff.
    check_bit("bottom_o", bottom_o, 1'b0); // Bottom only at zero.
    wb(1'b1, ADDR_COUNT, 8'h12, 4'h0);
    ticks(10);
    rd(ADDR_COUNT, 8'hff); // Stopped count holds.
    rd(8'h1c, 8'h00); // Unmapped reads zero.
    foreach (ovf_modes[k]) begin
      wr(ADDR_FLAG, 8'h03);
      wr(ADDR_COUNT, 8'hf8);
      wr(ADDR_CONTROL, {3'b000, ovf_modes[k], CS_DIV1});
      ticks(300);
      wr(ADDR_CONTROL, {3'b000, ovf_modes[k], CS_STOP});
      rd(ADDR_FLAG, 8'h01, 8'h01); // Overflow per mode.
    end
    wr(ADDR_FLAG, 8'h01);
    rd(ADDR_FLAG, 8'h00, 8'h01); // Written one clears.
    // Count write equal to compare loses that match.
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COMPARE, 8'h05);
    wr(ADDR_FLAG, 8'h03);
    wr(ADDR_COUNT, 8'h05);
    wr(ADDR_CONTROL, 8'h01);
    ticks(20);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_FLAG, 8'h00, 8'h02); // Match blocked.
    wr(ADDR_MASK, 8'h02);
    wr(ADDR_COMPARE, 8'h10);
    wr(ADDR_COUNT, 8'h0c);
    wr(ADDR_CONTROL, 8'h01);
    ticks(30);
    wr(ADDR_CONTROL, 8'h00);
    check_bit("compare_irq_o", compare_irq_o, 1'b0); // Global flag off.
    rd(ADDR_FLAG, 8'h02, 8'h02); // Match sets flag.
    gie <= 1'b1;
    k = 0;
    while (compare_irq_o !== 1'b1 && k < 10) begin
      @(posedge clk_i);
      k++;
    end
    check_bit("compare_irq_o", compare_irq_o, 1'b1); // Request raised.
    ticks(6);
    check_bit("compare_irq_o", compare_irq_o, 1'b0); // Request gone after take.
    rd(ADDR_FLAG, 8'h00, 8'h02); // Execution clears.
    wr(ADDR_MASK, 8'h01);
    wr(ADDR_COUNT, 8'hfd);
    wr(ADDR_CONTROL, {3'b000, WGM_NORMAL, CS_DIV1});
    k = 0;
    while (overflow_irq_o !== 1'b1 && k < 20) begin
      @(posedge clk_i);
      k++;
    end
    check_bit("overflow_irq_o", overflow_irq_o, 1'b1); // Overflow request raised.
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_FLAG, 8'h00, 8'h01); // Overflow execution clears.
    gie <= 1'b0;
    wr(ADDR_COMPARE, 8'h03);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CONTROL, {1'b0, COM_TOGGLE, WGM_CTC, CS_DIV1});
    ticks(40);
    rd(ADDR_COUNT, 8'h00, 8'hfc); // Compare is top.
    rd(ADDR_COUNT, 8'h00, 8'hfc); // Still within top.
    wr(ADDR_CONTROL, {1'b0, COM_NONE, WGM_CTC, CS_STOP});
    r = 8'h20 + 8'($urandom_range(95));
    wr(ADDR_CONTROL, {3'b000, WGM_FAST, CS_STOP});
    wr(ADDR_COMPARE, r);
    rd(ADDR_COMPARE, r); // Access reaches buffer.
    rd(ADDR_BUFFER, 8'h03); // Active value untouched.
    wr(ADDR_COUNT, 8'hfc);
    wr(ADDR_CONTROL, {3'b000, WGM_FAST, CS_DIV1});
    ticks(10);
    wr(ADDR_CONTROL, {3'b000, WGM_FAST, CS_STOP});
    rd(ADDR_BUFFER, r); // Loaded at top.
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COMPARE, 8'h55);
    rd(ADDR_BUFFER, 8'h55); // Direct when unbuffered.
    // Control commit to stop commit spans 61 waited cycles plus three bus cycles: 64 cycles, eight ticks.
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CONTROL, {3'b000, WGM_NORMAL, CS_DIV8});
    ticks(61);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_COUNT, 8'h08); // Prescaled tick rate.
    n_edges = $urandom_range(9) + 1;
    // First pass counts falling edges, second pass rising edges.
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_CONTROL, {3'b000, WGM_NORMAL, m ? 3'h7 : CS_EXT_FALL});
      repeat (n_edges) begin
        ticks(3);
        ext_pin <= 1'b0;
        ticks(3);
        ext_pin <= 1'b1;
      end
      ticks(4);
      wr(ADDR_CONTROL, 8'h00);
      rd(ADDR_COUNT, 8'(n_edges)); // One tick per chosen edge.
    end
    ticks(4);
    complete_run();
  end
endmodule : testbench
